// file: hdl/pin_engine_pkg.sv
// Purpose: Constants shared by the PIN verify and change engine.
// Assumes: APB with 32-bit data and byte addresses of 8 bits.
// Notes:   Status words are the two bytes returned to the terminal.
package pin_engine_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_SLOTS = 4;
  localparam int SLOT_W = 2;

  // Register byte addresses.
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] CMD_ADDR = 8'h04;
  localparam logic [7:0] DATA0_ADDR = 8'h08;
  localparam logic [7:0] DATA3_ADDR = 8'h14;
  localparam logic [7:0] STATUS_ADDR = 8'h18;
  localparam logic [7:0] ACCESS_ADDR = 8'h1c;
  localparam logic [7:0] SLOT_BASE = 8'h20;
  localparam logic [7:0] SLOT_LAST = 8'h2c;
  localparam logic [7:0] PIN_BASE = 8'h40;
  localparam logic [7:0] PIN_LAST = 8'h5c;

  // Field positions.
  localparam int CTRL_START = 0;
  localparam int CTRL_CMD_LSB = 1;
  localparam int CTRL_SESSION = 3;
  localparam int CTRL_BUSY = 4;
  localparam int STAT_BUSY = 16;
  localparam int STAT_DONE = 17;
  localparam int SLOT_DIS = 8;
  localparam int SLOT_VALID = 9;
  localparam int SLOT_UNBLOCK = 10;
  localparam int SLOT_CNT_LSB = 12;
  localparam int SLOT_BLOCKED = 14;
  localparam int SLOT_VERIFIED = 15;

  // Commands held in CTRL.
  localparam logic [1:0] CMD_VERIFY = 2'h0;
  localparam logic [1:0] CMD_CHANGE = 2'h1;

  // Command encodings and lengths.
  localparam logic [7:0] P1_NONE = 8'h00;
  localparam logic [7:0] LC_EMPTY = 8'h00;
  localparam logic [7:0] LC_PIN = 8'h08;
  localparam logic [7:0] LC_CHANGE = 8'h10;

  // Retry counter.
  localparam logic [1:0] TRIES_INIT = 2'h3;
  localparam logic [1:0] TRIES_NONE = 2'h0;

  // Status words.
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [15:0] SW_TRIES = 16'h63c0;
  localparam logic [15:0] SW_BLOCKED = 16'h6983;
  localparam logic [15:0] SW_NOT_USABLE = 16'h6984;
  localparam logic [15:0] SW_BAD_P1P2 = 16'h6a86;
  localparam logic [15:0] SW_NOT_FOUND = 16'h6a88;
  localparam logic [15:0] SW_BAD_LEN = 16'h6700;
  localparam logic [15:0] SW_BAD_INS = 16'h6d00;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_EXEC
  } state_t;

endpackage

// file: hdl/pin_verify_change_engine.sv
// Purpose: PIN verify and change engine with an APB register port.
// Assumes: Software copies each command's second parameter byte, data
//          length and data into registers, then writes start.
// Notes:   Retry counters reload 3 on presetn, a correct PIN or an unblock write,
//          and PIN values clear only on presetn; a session restart clears verified flags only.
// Behaviour
// - Compare PIN; status valid on every channel.
// - Verify only if PIN enabled and unblocked.
// - Guarded function needs verified or disabled PIN.
// - Correct PIN restores counter to 3.
// - Wrong PIN decrements counter, any channel.
// - First wrong presentation answers 63C2.
// - Second wrong answers 63C1; counter persists.
// - Third wrong blocks PIN, answers 63C0.
// - Verify on blocked PIN answers 6983.
// - Blocked PIN never grants access until unblocked; a disabled slot still grants it while blocked.
// - Empty verify data is a retry query.
// - Query answers 63CX with tries left.
// - Query on blocked PIN answers 63C0.
// - P2 selects PIN; reserved bits, zero invalid.
// - Change only if enabled, unblocked, old and new.
// - Correct old PIN: counter 3, new value.
// - New PIN value shared by all channels.
// - Wrong old PIN decrements, keeps value, blocks.
//
// The placing of the registers and the APB slave port are this design's own decisions.
module pin_verify_change_engine
  import pin_engine_pkg::*;
(
  input wire logic pclk, // APB clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // Slave select
  input wire logic penable, // Access phase
  input wire logic pwrite, // Write when high
  input wire logic [pin_engine_pkg::ADDR_W-1:0] paddr, // Byte address
  input wire logic [pin_engine_pkg::DATA_W-1:0] pwdata, // Write data
  output logic pready, // Transfer complete
  output logic pslverr, // Unmapped address
  output logic [pin_engine_pkg::DATA_W-1:0] prdata // Read data
);

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
    state_t state;
    logic [1:0] cmd_sel;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] lc;
    logic [3:0][DATA_W-1:0] data;
    logic [15:0] sw;
    logic done;
    logic [7:0] guard;
    logic [NUM_SLOTS-1:0][63:0] pin;
    logic [NUM_SLOTS-1:0][1:0] tries;
    logic [NUM_SLOTS-1:0][7:0] keyref;
    logic [NUM_SLOTS-1:0] disabled;
    logic [NUM_SLOTS-1:0] valid;
    logic [NUM_SLOTS-1:0] verified;
  } regs_t;

  regs_t q;
  regs_t next_q;

  // ----------------------------------------------------------------
  // Slot lookup
  // ----------------------------------------------------------------
  logic [NUM_SLOTS-1:0] cmd_hit;
  logic [NUM_SLOTS-1:0] guard_hit;
  logic [NUM_SLOTS-1:0] slot_open;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SLOTS; gi++)
    begin : g_slot
      // PIN reference lookup
      // match P2 byte
      assign cmd_hit[gi] = q.valid[gi] && (q.keyref[gi] == q.p2);
      assign guard_hit[gi] = q.valid[gi] && (q.keyref[gi] == q.guard);
      // Access gate
      // verified or disabled
      assign slot_open[gi] = q.disabled[gi] ||
        (q.verified[gi] && (q.tries[gi] != TRIES_NONE));
    end
  endgenerate

  logic [SLOT_W-1:0] cmd_idx;
  logic cmd_found;
  logic access_ok;
  logic p2_bad;
  logic [63:0] old_pin;
  logic [63:0] new_pin;
  logic [1:0] tries_left;
  logic addr_ok;
  logic [SLOT_W-1:0] reg_idx;

  always_comb
  begin
    // The lowest matching slot wins; software keeps references unique.
    cmd_idx = '0;
    cmd_found = 1'b0;
    // A guard of zero means the function needs no PIN at all.
    access_ok = (q.guard == P1_NONE);
    for (int i = 0; i < NUM_SLOTS; i++)
    begin
      if (cmd_hit[i] && !cmd_found)
      begin
        cmd_idx = SLOT_W'(i);
        cmd_found = 1'b1;
      end
      if (guard_hit[i] && slot_open[i])
      begin
        access_ok = 1'b1;
      end
    end
  end

  // Parameter check
  // reserved bits and zero
  // P1 must be 00
  // A reference number of zero names no PIN, global or specific.
  assign p2_bad = (q.p1 != P1_NONE) || (q.p2[4:0] == 5'h00) ||
                  (q.p2[6:5] != 2'h0);
  assign old_pin = {q.data[1], q.data[0]};
  assign new_pin = {q.data[3], q.data[2]};
  // Read only after the blocked check, so it never wraps below zero.
  assign tries_left = q.tries[cmd_idx] - 2'h1;
  assign reg_idx = paddr[3:2];

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Only aligned words inside the three register windows are mapped.
  always_comb
  begin
    addr_ok = 1'b0;
    if ((paddr[1:0] == 2'h0) &&
        ((paddr <= ACCESS_ADDR) ||
         (paddr >= SLOT_BASE && paddr <= SLOT_LAST) ||
         (paddr >= PIN_BASE && paddr <= PIN_LAST)))
    begin
      addr_ok = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_q = q;
    next_q.pready = 1'b0;
    next_q.pslverr = 1'b0;

    // ----------------------------------------------------------------
    // Register read
    // ----------------------------------------------------------------
    // Setup phase: latch read data so the access phase sees a flop.
    // The ready term keeps each answer to a single cycle.
    if (psel && !penable && !q.pready)
    begin
      next_q.pready = 1'b1;
      next_q.pslverr = !addr_ok;
      next_q.prdata = '0;
      if (!addr_ok)
      begin
        next_q.prdata = '0;
      end
      else if (paddr == CTRL_ADDR)
      begin
        next_q.prdata[CTRL_CMD_LSB +: 2] = q.cmd_sel;
        next_q.prdata[CTRL_BUSY] = (q.state == ST_EXEC);
      end
      else if (paddr == CMD_ADDR)
      begin
        next_q.prdata[23:0] = {q.lc, q.p2, q.p1};
      end
      else if (paddr >= DATA0_ADDR && paddr <= DATA3_ADDR)
      begin
        next_q.prdata = q.data[SLOT_W'((paddr - DATA0_ADDR) >> 2)];
      end
      else if (paddr == STATUS_ADDR)
      begin
        next_q.prdata[15:0] = q.sw;
        next_q.prdata[STAT_BUSY] = (q.state == ST_EXEC);
        next_q.prdata[STAT_DONE] = q.done;
      end
      else if (paddr == ACCESS_ADDR)
      begin
        next_q.prdata[15:8] = q.guard;
        next_q.prdata[0] = access_ok;
      end
      else if (paddr <= SLOT_LAST)
      begin
        next_q.prdata[7:0] = q.keyref[reg_idx];
        next_q.prdata[SLOT_DIS] = q.disabled[reg_idx];
        next_q.prdata[SLOT_VALID] = q.valid[reg_idx];
        next_q.prdata[SLOT_CNT_LSB +: 2] = q.tries[reg_idx];
        next_q.prdata[SLOT_BLOCKED] = (q.tries[reg_idx] == TRIES_NONE);
        next_q.prdata[SLOT_VERIFIED] = q.verified[reg_idx];
      end
      else
      begin
        // Stored PIN values are write-only.
        next_q.prdata = '0;
      end
      // A write answers with zero on the read bus.
      if (pwrite)
      begin
        next_q.prdata = '0;
      end
    end

    // ----------------------------------------------------------------
    // Register write
    // ----------------------------------------------------------------
    // Access phase: writes take effect here only.
    if (psel && penable && q.pready && pwrite && addr_ok)
    begin
      if (paddr == CTRL_ADDR)
      begin
        // Session restart drops verified flags but keeps the counters.
        if (pwdata[CTRL_SESSION])
        begin
          next_q.verified = '0;
        end
        if (pwdata[CTRL_START] && q.state == ST_IDLE)
        begin
          next_q.cmd_sel = pwdata[CTRL_CMD_LSB +: 2];
          next_q.state = ST_EXEC;
          next_q.done = 1'b0;
        end
      end
      else if (paddr == CMD_ADDR)
      begin
        {next_q.lc, next_q.p2, next_q.p1} = pwdata[23:0];
      end
      else if (paddr >= DATA0_ADDR && paddr <= DATA3_ADDR)
      begin
        next_q.data[SLOT_W'((paddr - DATA0_ADDR) >> 2)] = pwdata;
      end
      else if (paddr == ACCESS_ADDR)
      begin
        next_q.guard = pwdata[15:8];
      end
      else if (paddr >= SLOT_BASE && paddr <= SLOT_LAST)
      begin
        next_q.keyref[reg_idx] = pwdata[7:0];
        next_q.disabled[reg_idx] = pwdata[SLOT_DIS];
        next_q.valid[reg_idx] = pwdata[SLOT_VALID];
        // Unblock refills the counter; the stored PIN is kept.
        if (pwdata[SLOT_UNBLOCK])
        begin
          next_q.tries[reg_idx] = TRIES_INIT;
        end
      end
      else if (paddr >= PIN_BASE)
      begin
        // Each slot holds its PIN as two words, low word first.
        next_q.pin[paddr[4:3]][paddr[2]*DATA_W +: DATA_W] = pwdata;
      end
    end

    // ----------------------------------------------------------------
    // Command execution
    // ----------------------------------------------------------------
    // Command execution: one cycle, after any session clear above.
    // The checks run in order, so a malformed command never reaches a
    // counter.
    if (q.state == ST_EXEC)
    begin
      next_q.state = ST_IDLE;
      next_q.done = 1'b1;
      if (q.cmd_sel != CMD_VERIFY && q.cmd_sel != CMD_CHANGE)
      begin
        next_q.sw = SW_BAD_INS;
      end
      // Bad reference byte
      // reject, counters untouched
      else if (p2_bad)
      begin
        next_q.sw = SW_BAD_P1P2;
      end
      else if (!cmd_found)
      begin
        next_q.sw = SW_NOT_FOUND;
      end
      // Retry counter query
      // empty data field
      else if (q.cmd_sel == CMD_VERIFY && q.lc == LC_EMPTY)
      begin
        next_q.sw = SW_TRIES | {14'h0, q.tries[cmd_idx]};
      end
      else if ((q.cmd_sel == CMD_VERIFY && q.lc != LC_PIN) ||
               (q.cmd_sel == CMD_CHANGE && q.lc != LC_CHANGE))
      begin
        next_q.sw = SW_BAD_LEN;
      end
      // Blocked PIN refusal
      // no verify when blocked
      else if (q.tries[cmd_idx] == TRIES_NONE)
      begin
        next_q.sw = SW_BLOCKED;
      end
      // Disabled PIN refusal
      // no verify when disabled
      else if (q.disabled[cmd_idx])
      begin
        next_q.sw = SW_NOT_USABLE;
      end
      // Correct presentation
      // shared security status
      else if (old_pin == q.pin[cmd_idx])
      begin
        next_q.tries[cmd_idx] = TRIES_INIT;
        next_q.verified[cmd_idx] = 1'b1;
        next_q.sw = SW_OK;
        if (q.cmd_sel == CMD_CHANGE)
        begin
          // Single PIN store
          // visible to all channels
          next_q.pin[cmd_idx] = new_pin;
        end
      end
      // Wrong presentation
      // decrement counter
      else
      begin
        next_q.tries[cmd_idx] = tries_left;
        next_q.verified[cmd_idx] = 1'b0;
        next_q.sw = SW_TRIES | {14'h0, tries_left};
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Reset clears PINs and loads each counter with 3; a session restart never
  // refunds an attempt.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.state <= ST_IDLE;
      q.sw <= SW_OK;
      q.tries <= {NUM_SLOTS{TRIES_INIT}};
    end
    else
    begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a field of the state register.
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign prdata = q.prdata;

endmodule

// file: dv/pin_engine_checker_properties.sv
// Purpose: Port checks of the PIN engine register port.
// Assumes: One clock, reset active low.
// Notes:   Bound to the engine below the module.
module pin_engine_checker
  import pin_engine_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // write
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic [31:0] prdata // read data
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_slot_rd;
    s_setup ##0 (!pwrite && paddr >= SLOT_BASE && paddr <= SLOT_LAST &&
      paddr[1:0] == 2'h0);
  endsequence
  sequence s_pin_rd;
    s_setup ##0 (!pwrite && paddr >= PIN_BASE && paddr <= PIN_LAST);
  endsequence
  AST_READY_AFTER_SETUP: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  AST_READY_SINGLE: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_UNALIGNED_ERR: assert property (s_setup ##0 paddr[1:0] != 2'h0
    |=> pslverr) else $error("unaligned access accepted");
  AST_ERR_DATA_ZERO: assert property (pslverr |-> prdata == 32'h0)
    else $error("data on error");
  AST_PIN_HIDDEN: assert property (s_pin_rd |=> prdata == 32'h0)
    else $error("pin value readable");
  AST_BLOCKED_TRIES: assert property (s_slot_rd
    |=> prdata[14] == (prdata[13:12] == 2'h0)) else $error("blocked flag");
  AST_BLOCKED_UNVERIFIED: assert property (s_slot_rd
    |=> !(prdata[14] && prdata[15])) else $error("blocked but verified");
endmodule

bind pin_verify_change_engine pin_engine_checker u_checker (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .prdata(prdata));

// file: dv/terminal_model.sv
// Purpose: Terminal side: bus master that loads and starts commands.
// Assumes: Called right after a rising clock edge.
// Notes:   gap adds idle cycles to model a slow terminal.
module terminal_model
  import pin_engine_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic [31:0] prdata, // read data
  output logic psel, // select
  output logic penable, // access
  output logic pwrite, // write
  output logic [7:0] paddr, // address
  output logic [31:0] pwdata // write data
);
  timeunit 1ns;
  timeprecision 1ns;
  bit hung = 0;
  int gap = 0;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
  end
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    hung = hung | (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    repeat (gap + 1) @(posedge pclk);
  endtask
  task cmd(input logic [1:0] c, input logic [7:0] p2, input logic [7:0] lc,
           input logic [63:0] o, input logic [63:0] nw);
    logic [31:0] r;
    logic e;
    xfer(1'b1, CMD_ADDR, {8'h0, lc, p2, P1_NONE}, r, e);
    xfer(1'b1, DATA0_ADDR, o[31:0], r, e);
    xfer(1'b1, DATA0_ADDR + 8'h4, o[63:32], r, e);
    xfer(1'b1, DATA0_ADDR + 8'h8, nw[31:0], r, e);
    xfer(1'b1, DATA3_ADDR, nw[63:32], r, e);
    xfer(1'b1, CTRL_ADDR, {29'h0, c, 1'b1}, r, e);
  endtask
endmodule

// file: dv/tb_top.sv
// Purpose: Self-checking bench of the PIN verify and change engine.
// Assumes: Engine answers each transfer in one access cycle.
// Notes:   Random verify traffic tracks the retry count.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pin_engine_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, berr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] pin0, pin1, pin1n;
  int err_count = 0;
  int tests_run = 0;
  int t;
  always #20 pclk = ~pclk;
  pin_verify_change_engine u_pin_verify_change_engine (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata));
  terminal_model u_terminal_model (.pclk(pclk), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  task final_report;
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    u_terminal_model.xfer(w, a, d, rd, berr);
    if (u_terminal_model.hung)
    begin
      err_count++;
      final_report();
    end
  endtask
  function logic [15:0] tries_sw(input int n);
    return SW_TRIES | 16'(n);
  endfunction
  task run(input logic [1:0] c, input logic [7:0] p2, input logic [7:0] lc,
           input logic [63:0] o, input logic [63:0] nw, input logic [15:0] e);
    u_terminal_model.cmd(c, p2, lc, o, nw);
    bus(1'b0, STATUS_ADDR, 32'h0);
    chk("status word", {16'h0, e}, {16'h0, rd[15:0]});
  endtask
  initial
  begin
    void'($urandom(32'h1a2ad9cd));
    pin0 = {$urandom, $urandom};
    pin1 = {$urandom, $urandom};
    pin1n = ~pin1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    run(2'h3, 8'h01, LC_EMPTY, 64'h0, 64'h0, SW_BAD_INS);
    bus(1'b0, SLOT_BASE, 32'h0);
    chk("tries", 32'h3, 32'(rd[13:12]));
    bus(1'b1, SLOT_BASE, 32'h201);
    bus(1'b1, SLOT_BASE + 8'h4, 32'h281);
    bus(1'b1, SLOT_BASE + 8'h8, 32'h302);
    bus(1'b1, PIN_BASE, pin0[31:0]);
    bus(1'b1, PIN_BASE + 8'h4, pin0[63:32]);
    bus(1'b1, PIN_BASE + 8'h8, pin1[31:0]);
    bus(1'b1, PIN_BASE + 8'hc, pin1[63:32]);
    bus(1'b1, ACCESS_ADDR, 32'h100);
    run(CMD_VERIFY, 8'h01, LC_EMPTY, 64'h0, 64'h0, tries_sw(3));
    bus(1'b0, ACCESS_ADDR, 32'h0);
    chk("grant", 32'h0, 32'(rd[0]));
    run(CMD_VERIFY, 8'h01, LC_PIN, pin0, 64'h0, SW_OK);
    bus(1'b0, ACCESS_ADDR, 32'h0);
    chk("grant", 32'h1, 32'(rd[0]));
    run(CMD_VERIFY, 8'h01, LC_PIN, ~pin0, 64'h0, tries_sw(2));
    run(CMD_VERIFY, 8'h01, LC_PIN, ~pin0, 64'h0, tries_sw(1));
    bus(1'b1, CTRL_ADDR, 32'h8);
    run(CMD_VERIFY, 8'h01, LC_PIN, ~pin0, 64'h0, tries_sw(0));
    run(CMD_VERIFY, 8'h01, LC_PIN, pin0, 64'h0, SW_BLOCKED);
    run(CMD_VERIFY, 8'h01, LC_EMPTY, 64'h0, 64'h0, tries_sw(0));
    bus(1'b0, ACCESS_ADDR, 32'h0);
    chk("grant", 32'h0, 32'(rd[0]));
    run(CMD_CHANGE, 8'h01, LC_CHANGE, pin0, pin1, SW_BLOCKED);
    bus(1'b1, SLOT_BASE, 32'h601);
    run(CMD_VERIFY, 8'h01, LC_PIN, pin0, 64'h0, SW_OK);
    run(CMD_CHANGE, 8'h81, LC_CHANGE, ~pin1, pin1n, tries_sw(2));
    run(CMD_VERIFY, 8'h81, LC_PIN, pin1, 64'h0, SW_OK);
    run(CMD_CHANGE, 8'h81, LC_CHANGE, pin1, pin1n, SW_OK);
    run(CMD_VERIFY, 8'h81, LC_PIN, pin1n, 64'h0, SW_OK);
    run(CMD_VERIFY, 8'h02, LC_PIN, pin0, 64'h0, SW_NOT_USABLE);
    run(CMD_VERIFY, 8'h00, LC_PIN, pin0, 64'h0, SW_BAD_P1P2);
    run(CMD_VERIFY, 8'h21, LC_PIN, ~pin0, 64'h0, SW_BAD_P1P2);
    run(CMD_VERIFY, 8'h41, LC_PIN, ~pin0, 64'h0, SW_BAD_P1P2);
    run(CMD_VERIFY, 8'h80, LC_PIN, ~pin0, 64'h0, SW_BAD_P1P2);
    run(CMD_CHANGE, 8'h01, LC_PIN, ~pin0, pin1, SW_BAD_LEN);
    run(CMD_VERIFY, 8'h01, LC_EMPTY, 64'h0, 64'h0, tries_sw(3));
    run(CMD_VERIFY, 8'h05, LC_PIN, pin0, 64'h0, SW_NOT_FOUND);
    t = 3;
    repeat (24)
    begin
      u_terminal_model.gap = $urandom_range(0, 2);
      if (t == 0)
      begin
        run(CMD_VERIFY, 8'h81, LC_PIN, pin1n, 64'h0, SW_BLOCKED);
        bus(1'b1, SLOT_BASE + 8'h4, 32'h681);
        t = 3;
      end
      else if ($urandom_range(0, 2) == 0)
      begin
        run(CMD_VERIFY, 8'h81, LC_PIN, pin1n, 64'h0, SW_OK);
        t = 3;
      end
      else
      begin
        t--;
        run(CMD_VERIFY, 8'h81, LC_PIN, pin1n ^ {$urandom, $urandom | 32'h1},
            64'h0, tries_sw(t));
      end
    end
    bus(1'b0, 8'hfc, 32'h0);
    chk("unmapped error", 32'h1, 32'(berr));
    bus(1'b1, 8'h01, 32'h0);
    chk("unaligned error", 32'h1, 32'(berr));
    final_report();
  end
endmodule
